// ==== verilog/dcmaint_pkg.sv ====
// Purpose: shared constants for the data-cache block maintenance unit
// Assumes: 32-bit addresses, AXI4-Lite register access
// Notes:   operation codes and slot are fixed by the instruction set
package dcmaint_pkg;
	// ----------------------------------------------------------------
	// operation decode
	// ----------------------------------------------------------------
	localparam logic [7:0]  OPC_COPYBACK   = 8'hCD;
	localparam logic [7:0]  OPC_INVALIDATE = 8'hCE;
	localparam logic [2:0]  ISSUE_SLOT     = 3'h5;
	localparam int          DISP_W         = 7;
	localparam int          DISP_SHIFT     = 2;
	localparam int          ADDR_W         = 32;
	// ----------------------------------------------------------------
	// register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [4:0]  REG_CTRL       = 5'h00;
	localparam logic [4:0]  REG_NC_BASE    = 5'h04;
	localparam logic [4:0]  REG_NC_LIMIT   = 5'h08;
	localparam logic [4:0]  REG_STATUS     = 5'h0C;
	localparam logic [4:0]  REG_CB_COUNT   = 5'h10;
	localparam logic [4:0]  REG_INV_COUNT  = 5'h14;
	localparam int          CTRL_ENABLE    = 0;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
	localparam logic [31:0] NC_BASE_RESET  = 32'h0000_0000;
	localparam logic [31:0] NC_LIMIT_RESET = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// ----------------------------------------------------------------
	// sequencer states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE      = 4'h1,
		ST_LOOKUP    = 4'h2,
		ST_WRITEBACK = 4'h4,
		ST_FINISH    = 4'h8
	} mstate_e;
endpackage

// ==== verilog/dcmaint_addr.sv ====
// Purpose: target address and uncached-aperture check
// Assumes: displacement is a signed word count, scaled by four
// Notes:   purely combinational, sampled by the sequencer at issue
`timescale 1ns/1ps
`default_nettype none
module dcmaint_addr
	import dcmaint_pkg::*;
(
	// operands
	input  wire logic [dcmaint_pkg::ADDR_W-1:0] base_source_operand,
	input  wire logic [dcmaint_pkg::DISP_W-1:0] displacement,
	// aperture window
	input  wire logic [31:0]                    nc_base,
	input  wire logic [31:0]                    nc_limit,
	// results
	output logic      [dcmaint_pkg::ADDR_W-1:0] target_addr,
	output logic                                uncached
);
	logic [ADDR_W-1:0] offset;

	// sign-extend then scale; low bits stay zero, so alignment holds
	assign offset = {{(ADDR_W-DISP_W-DISP_SHIFT){displacement[DISP_W-1]}},
		displacement, {DISP_SHIFT{1'b0}}};
	assign target_addr = base_source_operand + offset;
	// empty window when limit is not above base
	assign uncached = (target_addr >= nc_base) && (target_addr < nc_limit);
endmodule
`default_nettype wire

// ==== verilog/dcmaint_unit.sv ====
// Purpose: data-cache copyback and invalidate block operations
// Assumes: cache answers a lookup in the cycle lookup_req is high
// Notes:   one operation at a time; issue while busy is ignored
//
// How it works
// - copyback writes the block out only if valid and dirty, then clears dirty.
// - target is the block holding base operand plus signed displacement.
// - after copyback the block stays resident and valid.
// - the core is stalled until the block writeback completes.
// - absent or clean target means no action and no stall.
// - copyback does nothing on addresses in the uncached aperture.
// - maintenance never alters data-cache replacement state.
// - copyback cancels pending prefetches and drains copyback buffers.
// - a guard with LSB zero turns the operation into a no-op, no stall.
// - copyback is opcode 205, slot 5, latency 3.
// - invalidate of a valid block clears its valid and dirty bits.
// - invalidate is opcode 206, slot 5, latency 3.
// - invalidate never writes the block to main memory.
// - invalidate clears valid even on locked blocks.
// - invalidate cancels prefetches, drains buffers, no stall if absent.
`timescale 1ns/1ps
`default_nettype none
module dcmaint_unit
	import dcmaint_pkg::*;
(
	// clock and reset
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	// operation issue
	input  wire logic                           op_valid,
	input  wire logic [7:0]                     op_code,
	input  wire logic [2:0]                     op_slot,
	input  wire logic                           guard_present,
	input  wire logic [31:0]                    guard_value,
	input  wire logic [dcmaint_pkg::ADDR_W-1:0] base_source_operand,
	input  wire logic [dcmaint_pkg::DISP_W-1:0] displacement,
	output logic                                op_done,
	output logic                                stall,
	// cache tag port
	output logic                                lookup_req,
	output logic                                lookup_keep_lru,
	output logic      [dcmaint_pkg::ADDR_W-1:0] cache_addr,
	input  wire logic                           lookup_valid,
	input  wire logic                           lookup_dirty,
	output logic                                clear_valid,
	output logic                                clear_dirty,
	// memory side
	output logic                                wb_req,
	input  wire logic                           wb_done,
	output logic                                prefetch_cancel,
	output logic                                buffer_flush,
	// axi4-lite slave
	input  wire logic [4:0]                     s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic      [1:0]                     s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [4:0]                     s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic      [31:0]                    s_axi_rdata,
	output logic      [1:0]                     s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready
);
	import dcmaint_pkg::*;

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	mstate_e           state;
	logic [31:0]       ctrl;
	logic [31:0]       nc_base;
	logic [31:0]       nc_limit;
	logic [31:0]       cb_count;
	logic [31:0]       inv_count;
	logic              is_copyback;
	logic [ADDR_W-1:0] target_addr;
	logic              uncached;
	logic              opc_ok;
	logic              take;
	logic [4:0]        aw_addr;
	logic              aw_held;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              w_held;
	logic              wr_go;
	logic [31:0]       next_rdata;
	logic              rd_hit;

	dcmaint_addr dcmaint_addr_i (
		.base_source_operand (base_source_operand),
		.displacement        (displacement),
		.nc_base             (nc_base),
		.nc_limit            (nc_limit),
		.target_addr         (target_addr),
		.uncached            (uncached)
	);

	// ----------------------------------------------------------------
	// issue decode
	// ----------------------------------------------------------------
	assign opc_ok = (op_code == OPC_COPYBACK) || (op_code == OPC_INVALIDATE);
	// guard gates the whole op; uncached copyback is dropped too
	assign take = op_valid && opc_ok && (op_slot == ISSUE_SLOT)
		&& (!guard_present || guard_value[0])
		&& !(uncached && op_code == OPC_COPYBACK)
		&& ctrl[CTRL_ENABLE] && (state == ST_IDLE);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take) begin
						state <= ST_LOOKUP;
					end
				end
				ST_LOOKUP: begin
					// only a dirty valid copyback waits on memory
					if (is_copyback && lookup_valid && lookup_dirty) begin
						state <= ST_WRITEBACK;
					end else begin
						state <= ST_FINISH;
					end
				end
				ST_WRITEBACK: begin
					if (wb_done) begin
						state <= ST_FINISH;
					end
				end
				ST_FINISH: state <= ST_IDLE;
				default:   state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			is_copyback <= 1'b0;
			cache_addr  <= '0;
		end else if (take) begin
			is_copyback <= (op_code == OPC_COPYBACK);
			cache_addr  <= target_addr;
		end
	end

	// tag port and coherency pulses in the cycle after issue
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lookup_req      <= 1'b0;
			lookup_keep_lru <= 1'b0;
			prefetch_cancel <= 1'b0;
			buffer_flush    <= 1'b0;
		end else begin
			lookup_req      <= take;
			lookup_keep_lru <= take;
			prefetch_cancel <= take;
			buffer_flush    <= take;
		end
	end

	// writeback and stall held until memory reports completion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wb_req <= 1'b0;
			stall  <= 1'b0;
		end else if (state == ST_LOOKUP) begin
			// invalidate never writes out, dirty or not
			wb_req <= is_copyback && lookup_valid && lookup_dirty;
			stall  <= is_copyback && lookup_valid && lookup_dirty;
		end else if (wb_done) begin
			wb_req <= 1'b0;
			stall  <= 1'b0;
		end
	end

	// state bit updates; lock status is deliberately not consulted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clear_valid <= 1'b0;
			clear_dirty <= 1'b0;
		end else begin
			clear_valid <= (state == ST_LOOKUP) && !is_copyback
				&& lookup_valid;
			clear_dirty <= ((state == ST_LOOKUP) && !is_copyback
				&& lookup_valid)
				|| ((state == ST_WRITEBACK) && wb_done);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_done <= 1'b0;
		end else begin
			op_done <= (state == ST_FINISH);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cb_count  <= '0;
			inv_count <= '0;
		end else if (state == ST_FINISH) begin
			if (is_copyback) begin
				cb_count <= cb_count + 32'h0000_0001;
			end else begin
				inv_count <= inv_count + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write path
	// ----------------------------------------------------------------
	assign wr_go = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held  <= 1'b0;
			w_data  <= '0;
			w_strb  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl     <= CTRL_RESET;
			nc_base  <= NC_BASE_RESET;
			nc_limit <= NC_LIMIT_RESET;
		end else if (wr_go) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b]) begin
					case (aw_addr)
						REG_CTRL:     ctrl[b*8 +: 8]     <= w_data[b*8 +: 8];
						REG_NC_BASE:  nc_base[b*8 +: 8]  <= w_data[b*8 +: 8];
						REG_NC_LIMIT: nc_limit[b*8 +: 8] <= w_data[b*8 +: 8];
						default:      ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == REG_CTRL || aw_addr == REG_NC_BASE
				|| aw_addr == REG_NC_LIMIT) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read path
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = '0;
		rd_hit     = 1'b1;
		case (s_axi_araddr)
			REG_CTRL:      next_rdata = ctrl;
			REG_NC_BASE:   next_rdata = nc_base;
			REG_NC_LIMIT:  next_rdata = nc_limit;
			REG_STATUS:    next_rdata = {26'h0, stall, is_copyback, state};
			REG_CB_COUNT:  next_rdata = cb_count;
			REG_INV_COUNT: next_rdata = inv_count;
			default:       rd_hit     = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CLEAN_DIRTY_AFTER_WB: assert property (
		wb_req && wb_done |=> clear_dirty && !clear_valid)
		else $error("dirty bit not cleared after writeback");
	AST_TARGET_ADDR: assert property (
		take |=> lookup_req && cache_addr == $past(target_addr))
		else $error("lookup address differs from base plus displacement");
	AST_KEEP_VALID: assert property (
		lookup_req && is_copyback |-> ##1 !clear_valid [*3])
		else $error("copyback invalidated its block");
	AST_STALL_UNTIL_DONE: assert property (
		stall && !wb_done |=> stall)
		else $error("stall dropped before writeback completed");
	AST_NO_STALL_CLEAN: assert property (
		lookup_req && !(lookup_valid && lookup_dirty) |=> !stall ##1 !stall)
		else $error("stall taken for a clean or absent block");
	AST_UNCACHED_NOP: assert property (
		op_valid && op_code == OPC_COPYBACK && uncached |=> !lookup_req)
		else $error("uncached copyback was accepted");
	AST_LRU_KEPT: assert property (
		lookup_req |-> lookup_keep_lru)
		else $error("lookup may disturb replacement state");
	AST_COHERENCY: assert property (
		$rose(state == ST_LOOKUP) |-> prefetch_cancel && buffer_flush)
		else $error("prefetch cancel or buffer drain missing");
	AST_GUARD_FALSE: assert property (
		guard_present && !guard_value[0] |=> !lookup_req && !stall)
		else $error("guarded-off operation took effect");
	AST_LATENCY: assert property (
		take ##1 !(is_copyback && lookup_valid && lookup_dirty)
		|=> ##1 op_done)
		else $error("operation did not complete in three cycles");
	AST_INV_CLEARS: assert property (
		lookup_req && !is_copyback && lookup_valid
		|=> clear_valid && clear_dirty)
		else $error("invalidate did not clear valid and dirty");
	AST_INV_NO_WB: assert property (
		lookup_req && !is_copyback |=> !wb_req)
		else $error("invalidate wrote block to memory");

	COV_COPYBACK_DIRTY: cover property (wb_req && wb_done);
	COV_COPYBACK_CLEAN: cover property (
		lookup_req && is_copyback && !lookup_dirty);
	COV_INVALIDATE: cover property (clear_valid);
	COV_GUARD_OFF: cover property (op_valid && guard_present
		&& !guard_value[0]);
endmodule
`default_nettype wire

// ==== dv/cache_mem_model.sv ====
// Purpose: cache tag port and main memory stand-in
// Assumes: tag lookup answered in the cycle of lookup_req
// Notes:   writeback delay chosen per operation by the bench
`timescale 1ns/1ps
`default_nettype none
module cache_mem_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// bench settings
	input  wire logic       blk_valid,
	input  wire logic       blk_dirty,
	input  wire logic [3:0] wb_delay,
	// tag and memory side
	input  wire logic       lookup_req,
	output logic            lookup_valid,
	output logic            lookup_dirty,
	input  wire logic       wb_req,
	output logic            wb_done
);
	logic       tog;
	logic [3:0] cnt;
	// ----------------------------------------------------------------
	// tag answer
	// ----------------------------------------------------------------
	// lines wander outside a lookup, so a late sample shows up
	assign lookup_valid = lookup_req ? blk_valid : tog;
	assign lookup_dirty = lookup_req ? blk_dirty : ~tog;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tog <= 1'b0;
		else
			tog <= ~tog;
	end
	// ----------------------------------------------------------------
	// writeback completion
	// ----------------------------------------------------------------
	// one pulse per request; delay 0 answers promptly
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt     <= 4'h0;
			wb_done <= 1'b0;
		end else begin
			cnt     <= wb_req ? cnt + 4'h1 : 4'h0;
			wb_done <= wb_req && !wb_done && cnt == wb_delay;
		end
	end
endmodule
`default_nettype wire

// ==== dv/dcache_block_maintenance_ops_test.sv ====
// Purpose: self-checking bench for the block maintenance unit
// Assumes: registered outputs, latencies as handed over
// Notes:   expected results queued by drivers, checked by monitor
`timescale 1ns/1ps
`default_nettype none
module dcache_block_maintenance_ops_test;
	import dcmaint_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        aclk = 1'b0, aresetn = 1'b0, op_valid = 1'b0;
	logic [7:0]  op_code = 8'h00;
	logic [2:0]  op_slot = 3'h0;
	logic        gp = 1'b0, blk_valid = 1'b0, blk_dirty = 1'b0;
	logic [31:0] gv = 32'h0, base = 32'h0, wdata = 32'h0, rv;
	logic [6:0]  disp = 7'h00;
	logic [3:0]  dly = 4'h0, wstrb = 4'hF;
	logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        op_done, stall, lk_req, lru, lk_v, lk_d, clr_v, clr_d;
	logic        wb_req, wb_done, pf_cancel, flush;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] cache_addr, rdata, r_addr;
	logic [1:0]  bresp, rresp;
	logic        r_wb, r_cv, r_cd, r_st, r_pf;
	logic [39:0] oq[$];
	logic [33:0] aq[$];
	int          seed = 17027, failures = 0, n_compared = 0;
	int          ncb = 0, ninv = 0, lat = 0;
	always #2 aclk = ~aclk;
	dcmaint_unit dcmaint_unit_i (
		.aclk(aclk), .aresetn(aresetn), .op_valid(op_valid),
		.op_code(op_code), .op_slot(op_slot), .guard_present(gp),
		.guard_value(gv), .base_source_operand(base), .displacement(disp),
		.op_done(op_done), .stall(stall), .lookup_req(lk_req),
		.lookup_keep_lru(lru), .cache_addr(cache_addr), .lookup_valid(lk_v),
		.lookup_dirty(lk_d), .clear_valid(clr_v), .clear_dirty(clr_d),
		.wb_req(wb_req), .wb_done(wb_done), .prefetch_cancel(pf_cancel),
		.buffer_flush(flush), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready)
	);
	cache_mem_model cache_mem_model_i (
		.aclk(aclk), .aresetn(aresetn), .blk_valid(blk_valid),
		.blk_dirty(blk_dirty), .wb_delay(dly), .lookup_req(lk_req),
		.lookup_valid(lk_v), .lookup_dirty(lk_d), .wb_req(wb_req),
		.wb_done(wb_done)
	);
	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp_op(input logic [39:0] e, input logic [39:0] g);
		n_compared++;
		if (e !== g) begin
			failures++;
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
		cmp_op({6'h00, e}, {6'h00, g});
	endtask
	task automatic tmo(input int n);
		if (n >= 64) begin
			failures++;
			$display("unexpected hang at %0t", $time);
			conclude();
		end
	endtask
	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic axi_w(input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int   n;
		logic pa, pw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aq.push_back({er, 32'h0});
		{n, pa, pw} = {32'd0, 2'b11};
		while (pa | pw) begin
			@(posedge aclk);
			n++;
			tmo(n);
			if (pa && awready === 1'b1) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready === 1'b1) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) begin
			@(posedge aclk);
			n++;
			tmo(n);
		end
		bready <= 1'b0;
	endtask
	task automatic axi_r(input logic [4:0] a, input logic [1:0] er,
		input logic [31:0] ed);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		aq.push_back({er, ed});
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			tmo(n);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) begin
			@(posedge aclk);
			n++;
			tmo(n);
		end
		rready <= 1'b0;
	endtask
	// tk: operation expected to be taken; bz: second issue while busy
	task automatic op(input logic [7:0] c, input logic [2:0] sl,
		input logic [1:0] g, input logic [31:0] b, input logic [6:0] d,
		input logic v, input logic dt, input logic tk, input logic bz);
		logic wb, iv;
		int   n;
		@(posedge aclk);
		wb = c == OPC_COPYBACK && v && dt;
		iv = c == OPC_INVALIDATE && v;
		blk_valid <= v;
		blk_dirty <= dt;
		dly <= 4'($unsigned($random(seed)) % 10);
		op_valid <= 1'b1;
		op_code <= c;
		op_slot <= sl;
		base <= b;
		disp <= d;
		gp <= g[1];
		gv <= {31'($random(seed)), g[0]};
		// done two after lookup, or two after wb_done when a writeback runs; lookup is one after issue
		if (tk)
			oq.push_back({b + {{23{d[6]}}, d, 2'b00}, wb, iv, iv | wb, wb,
				1'b1, 3'h2});
		if (tk && c == OPC_COPYBACK)
			ncb++;
		if (tk && c == OPC_INVALIDATE)
			ninv++;
		@(posedge aclk);
		op_valid <= bz;
		op_code <= OPC_INVALIDATE;
		@(posedge aclk);
		op_valid <= 1'b0;
		n = 0;
		repeat (tk ? 0 : 6) @(posedge aclk);
		while (tk && op_done !== 1'b1) begin
			@(posedge aclk);
			n++;
			tmo(n);
		end
	endtask
	// ----------------------------------------------------------------
	// monitor
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (aresetn) begin
			lat++;
			if (lk_req === 1'b1) begin
				if (oq.size() == 0)
					cmp_op(40'h0, {cache_addr, 8'hFF});
				r_addr = cache_addr;
				r_pf = pf_cancel & flush & lru;
				{r_wb, r_cv, r_cd, r_st} = 4'h0;
				lat = 0;
			end
			if (wb_req === 1'b1)
				r_wb = 1'b1;
			if (stall === 1'b1)
				r_st = 1'b1;
			if (clr_v === 1'b1)
				r_cv = 1'b1;
			if (clr_d === 1'b1)
				r_cd = 1'b1;
			if (wb_done === 1'b1)
				lat = 0;
			if (op_done === 1'b1 && oq.size() == 0)
				cmp_op(40'h0, 40'hFF);
			else if (op_done === 1'b1)
				cmp_op(oq.pop_front(), {r_addr, r_wb, r_cv, r_cd, r_st, r_pf,
					3'(lat)});
			if (bvalid === 1'b1 && bready && aq.size() > 0)
				cmp_bus(aq.pop_front(), {bresp, 32'h0});
			if (rvalid === 1'b1 && rready && aq.size() > 0)
				cmp_bus(aq.pop_front(), {rresp, rdata});
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axi_r(REG_CTRL, RESP_OKAY, CTRL_RESET);
		axi_r(REG_NC_BASE, RESP_OKAY, NC_BASE_RESET);
		axi_r(REG_NC_LIMIT, RESP_OKAY, NC_LIMIT_RESET);
		axi_r(REG_STATUS, RESP_OKAY, 32'h0000_0001);
		axi_r(5'h18, RESP_SLVERR, 32'h0000_0000);
		axi_w(REG_STATUS, 32'h0000_000F, 4'hF, RESP_SLVERR);
		axi_w(REG_NC_BASE, 32'hFFFF_FFFF, 4'h1, RESP_OKAY);
		axi_r(REG_NC_BASE, RESP_OKAY, 32'h0000_00FF);
		// every valid and dirty pairing, extreme displacements
		for (int i = 0; i < 8; i++)
			op(i[2] ? OPC_INVALIDATE : OPC_COPYBACK, ISSUE_SLOT, 2'b11,
				$random(seed), i[0] ? 7'h40 : 7'h3F, i[1], i[0], 1'b1,
				i == 3);
		for (int i = 0; i < 24; i++) begin
			rv = $random(seed);
			op(rv[0] ? OPC_INVALIDATE : OPC_COPYBACK, ISSUE_SLOT, rv[2:1],
				$random(seed), rv[9:3], rv[10], rv[11],
				rv[2:1] != 2'b10, 1'b0);
		end
		for (int i = 0; i < 4; i++)
			op(i[1] ? (i[0] ? 8'hCF : 8'h2D) : (i[0] ? OPC_INVALIDATE :
				OPC_COPYBACK), i[1] ? ISSUE_SLOT : 3'h4, 2'b00, 32'h100,
				7'h00, 1'b1, 1'b1, 1'b0, 1'b0);
		axi_w(REG_CTRL, 32'h0000_0000, 4'hF, RESP_OKAY);
		op(OPC_COPYBACK, ISSUE_SLOT, 2'b00, 32'h200, 7'h00, 1'b1, 1'b1,
			1'b0, 1'b0);
		axi_w(REG_CTRL, CTRL_RESET, 4'hF, RESP_OKAY);
		// uncached window edges
		axi_w(REG_NC_BASE, 32'h1000_0000, 4'hF, RESP_OKAY);
		axi_w(REG_NC_LIMIT, 32'h2000_0000, 4'hF, RESP_OKAY);
		op(OPC_COPYBACK, ISSUE_SLOT, 2'b00, 32'h1000_0100, 7'h40, 1'b1,
			1'b1, 1'b0, 1'b0);
		op(OPC_COPYBACK, ISSUE_SLOT, 2'b00, 32'h1000_0000, 7'h7F, 1'b1,
			1'b1, 1'b1, 1'b0);
		op(OPC_COPYBACK, ISSUE_SLOT, 2'b00, 32'h2000_0000, 7'h00, 1'b1,
			1'b1, 1'b1, 1'b0);
		op(OPC_INVALIDATE, ISSUE_SLOT, 2'b00, 32'h1800_0000, 7'h00, 1'b1,
			1'b1, 1'b1, 1'b0);
		axi_r(REG_CB_COUNT, RESP_OKAY, ncb);
		axi_r(REG_INV_COUNT, RESP_OKAY, ninv);
		repeat (4) @(posedge aclk);
		conclude();
	end
endmodule
`default_nettype wire
